// ===== design/buu_pkg.sv
// Purpose: constants, types and helpers of the usb to uart bridge core
// Assumes: mclk at 100 MHz, registers reached over apb, 32-bit words
// Notes:   offsets are byte addresses, one aligned word per register
// How it works
// - suspend signalling on usb puts the core into suspend, indicators asserted
// - the high-true suspend indicator is high while suspended
// - the low-true suspend indicator is always the complement
// - after reset both indicators stay asserted until enumeration completes
// - resume seen or generated, usb bus reset or device reset ends suspend
// - leaving suspend deasserts both indicators once enumeration has completed
// - during device reset both indicator pins are released, not driven
// - the function port moves all payload and takes uart control commands
// - flow control: rts/cts, dsr/dtr or in-band xon/xoff
// - frames are 8 data bits, 1 stop bit, parity none, even or odd
// - bit rate from a fixed list of 19 rates, 300 to 921600
// - with nothing stored, built-in identifiers and strings are reported
// - the configuration store is written over the function port only
// - default power attributes 80h and maximum power 0fh
// - stored serial string holds at most 63 characters
`default_nettype none
package buu_pkg;
	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TXD  = 8'h08;
	localparam logic [7:0] A_RXD  = 8'h0c;
	localparam logic [7:0] A_USB  = 8'h10;
	localparam logic [7:0] A_ID   = 8'h14;
	localparam logic [7:0] A_PWR  = 8'h18;
	localparam logic [7:0] A_SER  = 8'h1c;
	// field positions
	localparam int C_PAR  = 5;
	localparam int C_FLOW = 8;
	localparam int C_RTS  = 12;
	localparam int C_DTR  = 13;
	localparam int S_PERR = 0;
	localparam int S_FERR = 1;
	localparam int S_OVR  = 2;
	localparam int U_CFG  = 0;
	localparam int U_RES  = 1;
	localparam int P_MAXP = 8;
	localparam int P_SLEN = 16;
	localparam int R_SIDX = 8;
	localparam int R_SWR  = 15;
	// --------------------------------------------------------------
	// values
	// --------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int NBAUD  = 19;
	localparam int BAUD_TAB [NBAUD] = '{300, 600, 1200, 1800, 2400, 4800,
		7200, 9600, 14400, 19200, 28800, 38400, 56000, 57600, 115200,
		128000, 230400, 460800, 921600};
	localparam logic [4:0] BAUD_RST = 5'h07;
	localparam logic [7:0] ATTR_DEF = 8'h80;
	localparam logic [7:0] MAXP_DEF = 8'h0f;
	localparam logic [5:0] SER_MAX  = 6'h3f;
	localparam logic [5:0] SLEN_DEF = 6'h04;
	localparam logic [7:0] XON_CH   = 8'h11;
	localparam logic [7:0] XOFF_CH  = 8'h13;
	localparam logic [7:0] SYNC_RST = 8'h1f;
	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} buu_par_t;
	typedef enum logic [1:0] {FL_NONE, FL_RTS, FL_DSR, FL_XON} buu_flow_t;
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [19:0] baud_div(input logic [4:0] idx);
		baud_div = 20'(CLK_HZ / BAUD_TAB[idx]);
	endfunction
	localparam logic [19:0] DIV_RST = baud_div(BAUD_RST);
	function automatic logic par_on(input buu_par_t p);
		par_on = (p == PAR_EVEN) || (p == PAR_ODD);
	endfunction
	function automatic logic par_bit(input buu_par_t p, input logic [7:0] d);
		par_bit = (p == PAR_ODD) ? ~^d : ^d;
	endfunction
endpackage
`default_nettype wire

// ===== design/buu_uart_if.sv
// Purpose: link between the bridge core and its uart engine
// Assumes: both ends on mclk
// Notes:   tx_valid/tx_ready handshake, rx_valid one-cycle pulse
`default_nettype none
interface buu_uart_if;
	import buu_pkg::*;
	logic [19:0] div;
	buu_par_t    par;
	logic        tx_valid;
	logic        tx_ready;
	logic [7:0]  tx_data;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_perr;
	logic        rx_ferr;
	logic        busy;
	modport core (output div, par, tx_valid, tx_data,
		input tx_ready, rx_valid, rx_data, rx_perr, rx_ferr, busy);
	modport uart (input div, par, tx_valid, tx_data,
		output tx_ready, rx_valid, rx_data, rx_perr, rx_ferr, busy);
endinterface
`default_nettype wire

// ===== design/buu_uart.sv
// Purpose: uart frame engine, one start, 8 data, optional parity, 1 stop
// Assumes: rxd_s already synchronised to mclk
// Notes:   div clocks per bit, rx samples at mid-bit
`default_nettype none
module buu_uart
	import buu_pkg::*;
(
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic rxd_s,
	output logic      txd,
	buu_uart_if.uart  u
);
	typedef enum logic [1:0] {T_IDLE, T_RUN} buu_tst_t;
	typedef enum logic [1:0] {R_IDLE, R_START, R_BITS} buu_rst_t;
	typedef struct packed {
		buu_tst_t    ts;
		logic [19:0] tcnt;
		logic [3:0]  tbit;
		logic [10:0] tsh;
		logic        txd;
		buu_rst_t    rs;
		logic [19:0] rcnt;
		logic [3:0]  rbit;
		logic [9:0]  rsh;
		logic        rv;
		logic [7:0]  rd;
		logic        pe;
		logic        fe;
	} buu_ust_t;
	buu_ust_t   s;
	buu_ust_t   n;
	logic       pen;
	logic [9:0] nsh;
	logic [7:0] rdat;
	always_comb begin
		n = s;
		n.rv = 1'b0;
		pen = par_on(u.par);
		nsh = {rxd_s, s.rsh[9:1]};
		rdat = pen ? nsh[7:0] : nsh[8:1];
		case (s.ts)
			T_IDLE: if (u.tx_valid) begin
				n.ts = T_RUN;
				n.tcnt = u.div - 20'h1;
				n.tbit = pen ? 4'ha : 4'h9;
				n.tsh = {1'b1, pen ? par_bit(u.par, u.tx_data) : 1'b1, u.tx_data, 1'b0};
			end
			T_RUN: if (s.tcnt != 20'h0) begin
				n.tcnt = s.tcnt - 20'h1;
			end else if (s.tbit == 4'h0) begin
				n.ts = T_IDLE;
			end else begin
				n.tsh = {1'b1, s.tsh[10:1]};
				n.tbit = s.tbit - 4'h1;
				n.tcnt = u.div - 20'h1;
			end
			default: n.ts = T_IDLE;
		endcase
		n.txd = (n.ts == T_RUN) ? n.tsh[0] : 1'b1;
		case (s.rs)
			R_IDLE: if (!rxd_s) begin
				n.rs = R_START;
				n.rcnt = {1'b0, u.div[19:1]};
			end
			R_START: if (s.rcnt != 20'h0) begin
				n.rcnt = s.rcnt - 20'h1;
			end else if (!rxd_s) begin
				n.rs = R_BITS;
				n.rbit = pen ? 4'ha : 4'h9;
				n.rcnt = u.div - 20'h1;
			end else begin
				n.rs = R_IDLE;
			end
			R_BITS: if (s.rcnt != 20'h0) begin
				n.rcnt = s.rcnt - 20'h1;
			end else begin
				n.rsh = nsh;
				n.rbit = s.rbit - 4'h1;
				n.rcnt = u.div - 20'h1;
				if (s.rbit == 4'h1) begin
					n.rs = R_IDLE;
					n.rv = 1'b1;
					n.rd = rdat;
					n.fe = ~rxd_s;
					n.pe = pen & (nsh[8] != par_bit(u.par, nsh[7:0]));
				end
			end
			default: n.rs = R_IDLE;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.txd <= 1'b1;
		end else begin
			s <= n;
		end
	end
	assign txd = s.txd;
	assign u.tx_ready = (s.ts == T_IDLE);
	assign u.rx_valid = s.rv;
	assign u.rx_data = s.rd;
	assign u.rx_perr = s.pe;
	assign u.rx_ferr = s.fe;
	assign u.busy = (s.ts != T_IDLE) || (s.rs != R_IDLE);
endmodule // buu_uart
`default_nettype wire

// ===== design/buu_core.sv
// Purpose: usb to uart bridge core, suspend indicators, uart, config store
// Assumes: usb event levels come from the transceiver, asynchronous
// Notes:   apb slave with zero wait states, pready always high
`default_nettype none
module buu_core
	import buu_pkg::*;
#(
	parameter logic [15:0] DEF_VID = 16'h1234, // arbitrary value
	parameter logic [15:0] DEF_PID = 16'h5678, // arbitrary value
	parameter logic [31:0] DEF_SER = 32'h32423141 // arbitrary value
)(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        usb_susp_det,
	input  wire logic        usb_resume_det,
	input  wire logic        usb_bus_rst,
	output logic             usb_resume_req,
	input  wire logic        rxd,
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        dcd_n,
	input  wire logic        ri_n,
	output logic             txd,
	output logic             rts_n,
	output logic             dtr_n,
	output logic             susp_o,
	output logic             susp_oe,
	output logic             susp_n_o,
	output logic             susp_n_oe
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0]       sy1;
		logic [7:0]       sy2;
		logic [4:0]       baud;
		buu_par_t         par;
		buu_flow_t        flow;
		logic             rts_sw;
		logic             dtr_sw;
		logic             pend;
		logic [19:0]      div;
		buu_par_t         apar;
		logic             tx_full;
		logic [7:0]       tx_byte;
		logic             rx_full;
		logic [7:0]       rx_byte;
		logic             perr;
		logic             ferr;
		logic             ovr;
		logic             xoff_rx;
		logic             xpend;
		logic [7:0]       xch;
		logic             xoff_sent;
		logic             susp;
		logic             cfg_done;
		logic             ind;
		logic             oe;
		logic             res_req;
		logic             rts_n;
		logic             dtr_n;
		logic             custom;
		logic [15:0]      vid;
		logic [15:0]      pid;
		logic [7:0]       attr;
		logic [7:0]       maxp;
		logic [5:0]       slen;
		logic [5:0]       sidx;
		logic [63:0][7:0] ser;
		logic [31:0]      rdata;
		logic             serr;
	} buu_cst_t;

	buu_cst_t    s;
	buu_cst_t    n;
	buu_uart_if  ui ();
	logic        susp_s;
	logic        res_s;
	logic        brst_s;
	logic        rxd_s;
	logic        cts_s;
	logic        dsr_s;
	logic        dcd_s;
	logic        ri_s;
	logic        setup;
	logic        wr;
	logic        rd;
	logic        tx_ok;
	logic        tx_go;
	logic        res_gen;
	logic [7:0]  ch;
	logic [31:0] rv;

	// pins through two flops, only sy2 is read
	assign {susp_s, res_s, brst_s, rxd_s, cts_s, dsr_s, dcd_s, ri_s} = s.sy2;

	// --------------------------------------------------------------
	// uart engine
	// --------------------------------------------------------------
	buu_uart u_uart (
		.mclk   (mclk),
		.resetn (resetn),
		.rxd_s  (rxd_s),
		.txd    (txd),
		.u      (ui.uart)
	);

	assign ui.div = s.div;
	assign ui.par = s.apar;
	assign ui.tx_valid = tx_go;
	assign ui.tx_data = s.xpend ? s.xch : s.tx_byte;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		n = s;
		n.sy1 = {usb_susp_det, usb_resume_det, usb_bus_rst, rxd, cts_n, dsr_n, dcd_n, ri_n};
		n.sy2 = s.sy1;
		setup = psel & ~penable;
		wr = psel & penable & pwrite;
		rd = psel & penable & ~pwrite;
		rv = 32'h0;
		ch = 8'h0;

		// transmit permission per flow scheme
		case (s.flow)
			FL_RTS: tx_ok = ~cts_s;
			FL_DSR: tx_ok = ~dsr_s;
			FL_XON: tx_ok = ~s.xoff_rx;
			default: tx_ok = 1'b1;
		endcase
		// pending format change holds new frames back
		tx_go = ~s.pend & (s.xpend | (s.tx_full & tx_ok));
		if (tx_go & ui.tx_ready) begin
			if (s.xpend) begin
				n.xpend = 1'b0;
			end else begin
				n.tx_full = 1'b0;
			end
		end

		// apply format and rate only with the line idle
		if (s.pend & ~ui.busy) begin
			if (s.baud < NBAUD) begin
				n.div = baud_div(s.baud);
			end
			n.apar = s.par;
			n.pend = 1'b0;
		end

		// register read data, latched in the setup phase
		if (setup) begin
			n.serr = 1'b0;
			case (paddr)
				A_CTRL: begin
					rv[4:0] = s.baud;
					rv[C_PAR +: 2] = s.par;
					rv[C_FLOW +: 2] = s.flow;
					rv[C_RTS] = s.rts_sw;
					rv[C_DTR] = s.dtr_sw;
				end
				// stat: errors, buffers, flow, modem lines, store used
				A_STAT: rv = {20'h0, s.custom, ~ri_s, ~dcd_s, ~dsr_s, ~cts_s, s.pend,
					s.xoff_rx, s.rx_full, s.tx_full, s.ovr, s.ferr, s.perr};
				A_TXD: rv = {31'h0, s.tx_full};
				A_RXD: rv = {23'h0, s.rx_full, s.rx_byte};
				A_USB: rv = {29'h0, s.susp, s.cfg_done, s.ind};
				A_ID: rv = {s.pid, s.vid};
				A_PWR: rv = {10'h0, s.slen, s.maxp, s.attr};
				A_SER: begin
					if (s.sidx < s.slen) begin
						ch = s.ser[s.sidx];
					end
					rv = {18'h0, s.sidx, ch};
				end
				default: n.serr = 1'b1;
			endcase
			n.rdata = rv;
		end

		// reading received data frees the holding register
		if (rd && paddr == A_RXD) begin
			n.rx_full = 1'b0;
		end

		// register writes in the access phase
		res_gen = 1'b0;
		if (wr) begin
			case (paddr)
				A_CTRL: begin
					n.baud = pwdata[4:0];
					n.par = buu_par_t'(pwdata[C_PAR +: 2]);
					n.flow = buu_flow_t'(pwdata[C_FLOW +: 2]);
					n.rts_sw = pwdata[C_RTS];
					n.dtr_sw = pwdata[C_DTR];
					n.pend = 1'b1;
				end
				A_STAT: begin
					n.perr = s.perr & ~pwdata[S_PERR];
					n.ferr = s.ferr & ~pwdata[S_FERR];
					n.ovr = s.ovr & ~pwdata[S_OVR];
				end
				A_TXD: if (!s.tx_full) begin
					n.tx_full = 1'b1;
					n.tx_byte = pwdata[7:0];
				end
				A_USB: begin
					if (pwdata[U_CFG]) begin
						n.cfg_done = 1'b1;
					end
					res_gen = pwdata[U_RES];
				end
				A_ID: begin
					n.vid = pwdata[15:0];
					n.pid = pwdata[31:16];
					n.custom = 1'b1;
				end
				A_PWR: begin
					n.attr = pwdata[7:0];
					n.maxp = pwdata[P_MAXP +: 8];
					n.slen = (pwdata[P_SLEN +: 6] > SER_MAX) ? SER_MAX : pwdata[P_SLEN +: 6];
					n.custom = 1'b1;
				end
				A_SER: begin
					n.sidx = pwdata[R_SIDX +: 6];
					if (pwdata[R_SWR] && pwdata[R_SIDX +: 6] < SER_MAX) begin
						n.ser[pwdata[R_SIDX +: 6]] = pwdata[7:0];
						n.custom = 1'b1;
					end
				end
				default: n.custom = s.custom;
			endcase
		end

		// received characters, events win over clears
		if (ui.rx_valid) begin
			if (ui.rx_perr) begin
				n.perr = 1'b1;
			end
			if (ui.rx_ferr) begin
				n.ferr = 1'b1;
			end
			if (s.flow == FL_XON && ui.rx_data == XOFF_CH) begin
				n.xoff_rx = 1'b1;
			end else if (s.flow == FL_XON && ui.rx_data == XON_CH) begin
				n.xoff_rx = 1'b0;
			end else if (n.rx_full) begin
				n.ovr = 1'b1;
			end else begin
				n.rx_full = 1'b1;
				n.rx_byte = ui.rx_data;
			end
		end
		if (s.flow != FL_XON) begin
			n.xoff_rx = 1'b0;
			n.xoff_sent = 1'b0;
		end

		// in-band stop and go towards the peer
		if (s.flow == FL_XON && !n.xpend) begin
			if (n.rx_full && !n.xoff_sent) begin
				n.xpend = 1'b1;
				n.xch = XOFF_CH;
				n.xoff_sent = 1'b1;
			end else if (!n.rx_full && n.xoff_sent) begin
				n.xpend = 1'b1;
				n.xch = XON_CH;
				n.xoff_sent = 1'b0;
			end
		end
		n.rts_n = (s.flow == FL_RTS) ? n.rx_full : ~s.rts_sw;
		n.dtr_n = (s.flow == FL_DSR) ? n.rx_full : ~s.dtr_sw;

		// --------------------------------------------------------------
		// suspend
		// --------------------------------------------------------------
		n.res_req = res_gen & s.susp;
		if (brst_s | res_s | res_gen) begin
			n.susp = 1'b0;
		end else if (susp_s) begin
			n.susp = 1'b1;
		end
		n.ind = n.susp | ~n.cfg_done;
		n.oe = 1'b1;
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.sy1 <= SYNC_RST;
			s.sy2 <= SYNC_RST;
			s.baud <= BAUD_RST;
			s.div <= DIV_RST;
			s.ind <= 1'b1;
			s.oe <= 1'b0;
			s.rts_n <= 1'b1;
			s.dtr_n <= 1'b1;
			s.vid <= DEF_VID;
			s.pid <= DEF_PID;
			s.attr <= ATTR_DEF;
			s.maxp <= MAXP_DEF;
			s.slen <= SLEN_DEF;
			s.ser[3:0] <= DEF_SER;
		end else begin
			s <= n;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = s.serr & psel & penable;
	assign usb_resume_req = s.res_req;
	assign rts_n = s.rts_n;
	assign dtr_n = s.dtr_n;
	assign susp_o = s.ind;
	assign susp_n_o = ~s.ind;
	assign susp_oe = s.oe;
	assign susp_n_oe = s.oe;
endmodule // buu_core
`default_nettype wire

// ===== dv/buu_core_assertions.sv
// Purpose: checker on the ports of the bridge core
// Assumes: one clock mclk, synchronous low-true resetn
// Notes:   bound into buu_core below the module
`default_nettype none
module buu_core_chk (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic usb_susp_det,
	input wire logic usb_resume_det,
	input wire logic usb_bus_rst,
	input wire logic usb_resume_req,
	input wire logic txd,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic susp_o,
	input wire logic susp_oe,
	input wire logic susp_n_o,
	input wire logic susp_n_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------------------------
	// properties
	// ----------------------------------------------------------
	property p_rdy; pready; endproperty
	property p_err; pslverr |-> psel && penable; endproperty
	property p_comp; susp_n_o == !susp_o; endproperty
	property p_oe_rst; disable iff (1'b0) !resetn |=> !susp_oe && !susp_n_oe; endproperty
	property p_idle_rst; disable iff (1'b0) !resetn |=> txd && rts_n && dtr_n; endproperty
	property p_oe_pair; susp_oe == susp_n_oe; endproperty
	property p_boot; $rose(resetn) |=> susp_o && susp_oe; endproperty
	property p_entry;
		(usb_susp_det && !usb_resume_det && !usb_bus_rst)[*4] |-> susp_o;
	endproperty
	property p_rise;
		$rose(susp_o) && $past(resetn) |-> $past(usb_susp_det, 2) || $past(usb_susp_det, 3);
	endproperty
	property p_res; usb_resume_req |-> $past(susp_o) ##1 !usb_resume_req; endproperty
	a_rdy:      assert property (p_rdy) else $error("pready low");
	a_err:      assert property (p_err) else $error("pslverr outside access");
	a_comp:     assert property (p_comp) else $error("indicators not complementary");
	a_oe_rst:   assert property (p_oe_rst) else $error("indicator driven in reset");
	a_idle_rst: assert property (p_idle_rst) else $error("uart lines not idle in reset");
	a_oe_pair:  assert property (p_oe_pair) else $error("enables differ");
	a_boot:     assert property (p_boot) else $error("indicator not asserted after reset");
	a_entry:    assert property (p_entry) else $error("suspend not entered");
	a_rise:     assert property (p_rise) else $error("suspend without signalling");
	a_res:      assert property (p_res) else $error("resume pulse wrong");
	c_exit:  cover property (susp_o && susp_oe ##1 !susp_o);
	c_err:   cover property (pslverr);
	c_res:   cover property (usb_resume_req);
	c_start: cover property ($fell(txd));
endmodule // buu_core_chk
bind buu_core buu_core_chk u_buu_core_chk (.mclk(mclk), .resetn(resetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .usb_susp_det(usb_susp_det),
	.usb_resume_det(usb_resume_det), .usb_bus_rst(usb_bus_rst),
	.usb_resume_req(usb_resume_req), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
	.susp_o(susp_o), .susp_oe(susp_oe), .susp_n_o(susp_n_o), .susp_n_oe(susp_n_oe));
`default_nettype wire

// ===== dv/buu_peer.sv
// Purpose: uart peer on the far side of the bridge
// Assumes: DIV clocks per bit, 8 data, optional parity, 1 stop
// Notes:   par 0 none, 1 even, 2 odd
`default_nettype none
module buu_peer #(
	parameter int DIV = 108
)(
	input  wire logic       mclk,
	input  wire logic       txd,
	input  wire logic [1:0] par,
	output logic            rxd,
	output logic [7:0]      got,
	output logic [7:0]      n_got,
	output logic            got_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	logic       ok;
	initial begin
		rxd = 1'b1;
		n_got = 8'h00;
		got = 8'h00;
		got_ok = 1'b0;
		forever begin
			@(negedge txd);
			repeat (DIV / 2) @(posedge mclk);
			ok = (txd === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge mclk);
				sh[i] = txd;
			end
			if (par == 2'd1 || par == 2'd2) begin
				repeat (DIV) @(posedge mclk);
				ok &= (txd === ((par == 2'd2) ? ~^sh : ^sh));
			end
			repeat (DIV) @(posedge mclk);
			ok &= (txd === 1'b1);
			got <= sh;
			got_ok <= ok;
			n_got <= n_got + 8'h01;
		end
	end
	task automatic send(input logic [7:0] b);
		logic [10:0] fr;
		int          n;
		n = (par == 2'd1 || par == 2'd2) ? 11 : 10;
		fr = {1'b1, (n == 11) ? ((par == 2'd2) ? ~^b : ^b) : 1'b1, b, 1'b0};
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			rxd <= fr[i];
			repeat (DIV - 1) @(posedge mclk);
		end
		@(posedge mclk);
	endtask
endmodule // buu_peer
`default_nettype wire

// ===== dv/test_usb_uart_bridge_suspend_cfg.sv
// Purpose: self-checking bench of the bridge core
// Assumes: apb master here, uart peer model on the serial side
// Notes:   reads queue their expected word, a monitor compares
`default_nettype none
module test_usb_uart_bridge_suspend_cfg
	import buu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 100_000_000 / 921600;
	localparam logic [15:0] VID = 16'h2b3c; // arbitrary value
	localparam logic [15:0] PID = 16'h4d5e; // arbitrary value
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, rxd, txd, rts_n, dtr_n;
	logic susp_det, resume_det, bus_rst, resume_req, susp_o, susp_oe, susp_n_o, susp_n_oe;
	logic [7:0]  paddr, got, n_got, b, n0;
	logic [31:0] pwdata, prdata, w;
	logic [1:0]  par_sel;
	logic [32:0] exp_q[$];
	int          err_total, n_tests;
	buu_core #(.DEF_VID(VID), .DEF_PID(PID)) u_buu_core (.mclk(mclk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_susp_det(susp_det),
		.usb_resume_det(resume_det), .usb_bus_rst(bus_rst), .usb_resume_req(resume_req),
		.rxd(rxd), .cts_n(1'b0), .dsr_n(1'b0), .dcd_n(1'b1), .ri_n(1'b1), .txd(txd),
		.rts_n(rts_n), .dtr_n(dtr_n), .susp_o(susp_o), .susp_oe(susp_oe),
		.susp_n_o(susp_n_o), .susp_n_oe(susp_n_oe));
	buu_peer #(.DIV(DIV)) u_buu_peer (.mclk(mclk), .txd(txd), .par(par_sel), .rxd(rxd),
		.got(got), .n_got(n_got), .got_ok());
	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
		n_tests++;
		if (seen !== ex) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] ex);
		exp_q.push_back(ex);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic pins(input logic [1:0] ex);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		chk("suspend pins", {31'h0, susp_o, susp_n_o}, {31'h0, ex});
		@(posedge mclk);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("prdata", {pslverr, prdata}, exp_q.pop_front());
	end
	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		give_verdict();
	end
	// ----------------------------------------------------------
	// tests
	// ----------------------------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, susp_det, resume_det, bus_rst} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		par_sel = 2'h0;
		void'($urandom(32'hadfa));
		repeat (5) @(posedge mclk);
		chk("enables", {31'h0, susp_oe, susp_n_oe}, 33'h0);
		resetn <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		chk("boot", {30'h0, susp_o, susp_n_o, susp_oe}, 33'h5);
		$display("test reset done");
		@(posedge mclk);
		rd(A_PWR, {11'h0, SLEN_DEF, 8'h0f, 8'h80});
		rd(A_ID, {1'b0, PID, VID});
		w = $urandom;
		apb(1'b1, A_ID, w);
		rd(A_ID, {1'b0, w});
		apb(1'b1, A_PWR, 32'h003f0f80);
		apb(1'b1, A_SER, {16'h0, 2'b10, 6'd62, 8'h41});
		rd(A_SER, {19'h0, 6'd62, 8'h41});
		apb(1'b1, A_SER, {16'h0, 2'b00, 6'd63, 8'h00});
		rd(A_SER, {19'h0, 6'd63, 8'h00});
		rd(8'h20, {1'b1, 32'h0});
		$display("test registers done");
		apb(1'b1, A_USB, 32'h1);
		pins(2'b01);
		for (int k = 0; k < 3; k++) begin
			susp_det <= 1'b1;
			pins(2'b10);
			susp_det <= 1'b0;
			if (k == 0) bus_rst <= 1'b1;
			if (k == 1) resume_det <= 1'b1;
			if (k == 2) apb(1'b1, A_USB, 32'h3);
			pins(2'b01);
			bus_rst <= 1'b0;
			resume_det <= 1'b0;
		end
		$display("test suspend done");
		for (int p = 0; p < 3; p++) begin
			par_sel <= 2'(p);
			apb(1'b1, A_CTRL, 32'((p == 1 ? 2 : 1) << 8 | p << 5 | 18));
			b = $urandom;
			n0 = n_got;
			apb(1'b1, A_TXD, {24'h0, b});
			for (int i = 0; i < 2000 && n_got == n0; i++) @(posedge mclk);
			chk("peer byte", {24'h0, u_buu_peer.got_ok, got}, {24'h0, 1'b1, b});
			b = $urandom;
			u_buu_peer.send(b);
			for (int i = 0; i < 500 && (p == 1 ? dtr_n : rts_n) !== 1'b1; i++) @(posedge mclk);
			chk("flow held", {32'h0, p == 1 ? dtr_n : rts_n}, 33'h1);
			rd(A_RXD, {24'h0, 1'b1, b});
			repeat (3) @(posedge mclk);
			chk("flow free", {32'h0, p == 1 ? dtr_n : rts_n}, 33'h0);
		end
		$display("test uart done");
		give_verdict();
	end
endmodule // test_usb_uart_bridge_suspend_cfg
`default_nettype wire
